// ### accel_config_irq_regs.v
// configuration and interrupt routing register bank of the acceleration sensor
//
// Summary of operation
// - bandwidth code bits 4:0, reset all ones, decoded 7.81 Hz up to 1000 Hz
// - power mode bit 7 enters suspend when set, resets to zero
// - power mode bit 6 enables reduced power operation, resets to zero
// - power mode bit 5 selects event-driven or equidistant sleep timing
// - power mode bits 4:1 set sleep length, codes up to five give 0.5 ms
// - data setup bit 7 picks filtered or unfiltered samples for output
// - data setup bit 6 set turns output data protection off
// - writing 0xb6 to soft reset register restores all defaults
// - slope enable bits 0..2 enable X, Y, Z slope interrupts
// - enable bits 4, 5, 6 enable new data, fifo full, fifo level
// - motion map bits 0 and 2 route significant motion and slope to pin a
// - motion map bits 5 and 7 route slope and significant motion to pin b
// - data map bits 0..2 route new data, level, full to pin a
// - each pin has programmable active level, default active high
`include "accel_map.vh"

module accel_config_irq_regs (
   input  wire        clk_sys,         // system clock, 25 MHz
   input  wire        rst,             // synchronous reset, active high
   input  wire [7:0]  reg_addr,        // register offset
   input  wire [7:0]  reg_wdata,       // write data
   input  wire        reg_wr,          // write strobe, one cycle
   input  wire        reg_rd,          // read strobe, one cycle
   output reg  [7:0]  reg_rdata,       // read data, valid after strobe
   input  wire [11:0] filt_x,          // filtered x sample
   input  wire [11:0] filt_y,          // filtered y sample
   input  wire [11:0] filt_z,          // filtered z sample
   input  wire [11:0] raw_x,           // unfiltered x sample
   input  wire [11:0] raw_y,           // unfiltered y sample
   input  wire [11:0] raw_z,           // unfiltered z sample
   input  wire        slope_evt_x,     // x slope event
   input  wire        slope_evt_y,     // y slope event
   input  wire        slope_evt_z,     // z slope event
   input  wire        sigmotion_evt,   // significant motion event
   input  wire        new_data_evt,    // new data event
   input  wire        queue_full_evt,  // fifo full event
   input  wire        queue_level_evt, // fifo watermark event
   output reg  [4:0]  filter_band_code, // bandwidth code
   output reg  [2:0]  band_rate_index, // 0 = 7.81 Hz .. 7 = 1000 Hz
   output reg         suspend_on,      // suspend mode
   output reg         reduced_power_enable, // reduced power mode
   output reg         equidistant_sleep, // sleep timer mode
   output reg  [3:0]  doze_length_code, // sleep duration code
   output reg  [3:0]  doze_length_index, // 0 = 0.5 ms .. 10 = 1000 ms
   output reg         unfiltered_select, // raw samples to output
   output reg         shadow_guard_off, // data protection disabled
   output reg         irq_pin_a,       // interrupt pin a
   output reg         irq_pin_b        // interrupt pin b
);

   reg  [2:0] slope_irq_enable;
   reg  [2:0] data_fifo_irq_enable;   // new, full, level
   reg  [3:0] motion_irq_pin_map;     // sig a, slope a, slope b, sig b
   reg  [5:0] data_irq_pin_map;       // new a, level a, full a, full b, level b, new b
   reg        pin_a_polarity;
   reg        pin_b_polarity;
   reg        soft_clear;
   wire       clr;
   wire       wr_hit_key;

   ////////////////////////////////////////////////////////////////////////////////
   // soft reset: the key write is stored for one cycle then clears the bank

   assign wr_hit_key = reg_wr && (reg_addr == `OFS_SOFT_RESET) &&
                       (reg_wdata == `SOFT_RESET_MAGIC);
   assign clr = rst | soft_clear;

   always @(posedge clk_sys) begin
      if (rst) begin
         soft_clear <= 1'b0;
      end else begin
         soft_clear <= wr_hit_key;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // writable registers, only defined bits are stored

   always @(posedge clk_sys) begin
      if (clr) begin
         filter_band_code     <= `BAND_RESET;
         suspend_on           <= 1'b0;
         reduced_power_enable <= 1'b0;
         equidistant_sleep    <= 1'b0;
         doze_length_code     <= 4'h0;
         unfiltered_select    <= 1'b0;
         shadow_guard_off     <= 1'b0;
         slope_irq_enable     <= 3'h0;
         data_fifo_irq_enable <= 3'h0;
         motion_irq_pin_map   <= 4'h0;
         data_irq_pin_map     <= 6'h00;
         {pin_b_polarity, pin_a_polarity} <= `PIN_CFG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_BANDWIDTH: begin
               filter_band_code <= reg_wdata[4:0];
            end
            `OFS_POWER_MODE: begin
               suspend_on           <= reg_wdata[`PM_SUSPEND_BIT];
               reduced_power_enable <= reg_wdata[`PM_REDUCED_BIT];
               equidistant_sleep    <= reg_wdata[`PM_TIMER_BIT];
               doze_length_code     <= reg_wdata[`PM_DOZE_HI:`PM_DOZE_LO];
            end
            `OFS_DATA_SETUP: begin
               unfiltered_select <= reg_wdata[`DS_RAW_BIT];
               shadow_guard_off  <= reg_wdata[`DS_GUARD_BIT];
            end
            `OFS_SLOPE_EN: begin
               slope_irq_enable <= {reg_wdata[`SE_Z_BIT], reg_wdata[`SE_Y_BIT],
                                    reg_wdata[`SE_X_BIT]};
            end
            `OFS_DATA_EN: begin
               data_fifo_irq_enable <= {reg_wdata[`DE_LEVEL_BIT], reg_wdata[`DE_FULL_BIT],
                                        reg_wdata[`DE_NEW_BIT]};
            end
            `OFS_MOTION_MAP: begin
               motion_irq_pin_map <= {reg_wdata[`MM_SIG_B_BIT], reg_wdata[`MM_SLOPE_B_BIT],
                                      reg_wdata[`MM_SLOPE_A_BIT],
                                      reg_wdata[`MM_SIG_A_BIT]};
            end
            `OFS_DATA_MAP: begin
               data_irq_pin_map <= {reg_wdata[`DM_NEW_B_BIT], reg_wdata[`DM_LEVEL_B_BIT],
                                    reg_wdata[`DM_FULL_B_BIT], reg_wdata[`DM_FULL_A_BIT],
                                    reg_wdata[`DM_LEVEL_A_BIT],
                                    reg_wdata[`DM_NEW_A_BIT]};
            end
            `OFS_PIN_CFG: begin
               pin_a_polarity <= reg_wdata[`PC_A_LEVEL_BIT];
               pin_b_polarity <= reg_wdata[`PC_B_LEVEL_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decoded rates, registered so every output leaves a flip-flop

   always @(posedge clk_sys) begin
      if (clr) begin
         band_rate_index   <= `BAND_FAST_INDEX;
         doze_length_index <= 4'h0;
      end else begin
         if (filter_band_code[4]) begin
            band_rate_index <= `BAND_FAST_INDEX;
         end else if (filter_band_code[3]) begin
            band_rate_index <= filter_band_code[2:0];
         end else begin
            band_rate_index <= `BAND_SLOW_INDEX;
         end
         if (doze_length_code <= `DOZE_SHORT_TOP) begin
            doze_length_index <= 4'h0;
         end else begin
            doze_length_index <= doze_length_code - `DOZE_SHORT_STEP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axis outputs with protection shadow

   wire [11:0] sel_x = unfiltered_select ? raw_x : filt_x;
   wire [11:0] sel_y = unfiltered_select ? raw_y : filt_y;
   wire [11:0] sel_z = unfiltered_select ? raw_z : filt_z;
   wire [7:0]  x_lo;
   wire [7:0]  x_hi;
   wire [7:0]  y_lo;
   wire [7:0]  y_hi;
   wire [7:0]  z_lo;
   wire [7:0]  z_hi;

   axis_shadow u_shadow_x (
      .clk_sys   (clk_sys),
      .clr       (clr),
      .sample    (sel_x),
      .guard_on  (~shadow_guard_off),
      .low_read  (reg_rd && (reg_addr == `OFS_XOUT_LO)),
      .low_byte  (x_lo),
      .high_byte (x_hi)
   );

   axis_shadow u_shadow_y (
      .clk_sys   (clk_sys),
      .clr       (clr),
      .sample    (sel_y),
      .guard_on  (~shadow_guard_off),
      .low_read  (reg_rd && (reg_addr == `OFS_YOUT_LO)),
      .low_byte  (y_lo),
      .high_byte (y_hi)
   );

   axis_shadow u_shadow_z (
      .clk_sys   (clk_sys),
      .clr       (clr),
      .sample    (sel_z),
      .guard_on  (~shadow_guard_off),
      .low_read  (reg_rd && (reg_addr == `OFS_ZOUT_LO)),
      .low_byte  (z_lo),
      .high_byte (z_hi)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // read path; reserved bits and the key register read zero

   reg [7:0] next_rdata;

   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `OFS_XOUT_LO:    next_rdata = x_lo;
         `OFS_XOUT_HI:    next_rdata = x_hi;
         `OFS_YOUT_LO:    next_rdata = y_lo;
         `OFS_YOUT_HI:    next_rdata = y_hi;
         `OFS_ZOUT_LO:    next_rdata = z_lo;
         `OFS_ZOUT_HI:    next_rdata = z_hi;
         `OFS_BANDWIDTH:  next_rdata = {3'h0, filter_band_code};
         `OFS_POWER_MODE: next_rdata = {suspend_on, reduced_power_enable, equidistant_sleep,
                                        doze_length_code, 1'b0};
         `OFS_DATA_SETUP: next_rdata = {unfiltered_select, shadow_guard_off, 6'h00};
         `OFS_SLOPE_EN:   next_rdata = {5'h00, slope_irq_enable};
         `OFS_DATA_EN:    next_rdata = {1'b0, data_fifo_irq_enable, 4'h0};
         `OFS_MOTION_MAP: next_rdata = {motion_irq_pin_map[3], 1'b0, motion_irq_pin_map[2],
                                        2'h0, motion_irq_pin_map[1], 1'b0,
                                        motion_irq_pin_map[0]};
         `OFS_DATA_MAP:   next_rdata = {data_irq_pin_map[5:3], 2'h0, data_irq_pin_map[2:0]};
         `OFS_PIN_CFG:    next_rdata = {5'h00, pin_b_polarity, 1'b0, pin_a_polarity};
         default:         next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk_sys) begin
      if (clr) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt routing, non-latched: pins follow the events one cycle later

   wire slope_any = |(slope_irq_enable & {slope_evt_z, slope_evt_y, slope_evt_x});
   wire new_on    = data_fifo_irq_enable[0] & new_data_evt;
   wire full_on   = data_fifo_irq_enable[1] & queue_full_evt;
   wire level_on  = data_fifo_irq_enable[2] & queue_level_evt;
   // significant motion has its enable outside this bank, so it is taken as enabled
   wire pin_a_any = (motion_irq_pin_map[0] & sigmotion_evt) |
                    (motion_irq_pin_map[1] & slope_any) |
                    (data_irq_pin_map[0] & new_on) |
                    (data_irq_pin_map[1] & level_on) |
                    (data_irq_pin_map[2] & full_on);
   wire pin_b_any = (motion_irq_pin_map[2] & slope_any) |
                    (motion_irq_pin_map[3] & sigmotion_evt) |
                    (data_irq_pin_map[3] & full_on) |
                    (data_irq_pin_map[4] & level_on) |
                    (data_irq_pin_map[5] & new_on);

   always @(posedge clk_sys) begin
      if (clr) begin
         irq_pin_a <= 1'b0;
         irq_pin_b <= 1'b0;
      end else begin
         irq_pin_a <= ~(pin_a_any ^ pin_a_polarity);
         irq_pin_b <= ~(pin_b_any ^ pin_b_polarity);
      end
   end

endmodule // accel_config_irq_regs

// ### accel_map.vh
// register offsets, field positions and reset values of the configuration bank
`ifndef ACCEL_MAP_VH
`define ACCEL_MAP_VH

`define OFS_XOUT_LO      8'h02
`define OFS_XOUT_HI      8'h03
`define OFS_YOUT_LO      8'h04
`define OFS_YOUT_HI      8'h05
`define OFS_ZOUT_LO      8'h06
`define OFS_ZOUT_HI      8'h07
`define OFS_BANDWIDTH    8'h10
`define OFS_POWER_MODE   8'h11
`define OFS_DATA_SETUP   8'h13
`define OFS_SOFT_RESET   8'h14
`define OFS_SLOPE_EN     8'h16
`define OFS_DATA_EN      8'h17
`define OFS_MOTION_MAP   8'h19
`define OFS_DATA_MAP     8'h1a
`define OFS_PIN_CFG      8'h20

`define SOFT_RESET_MAGIC 8'hb6
`define BAND_RESET       5'h1f
`define PIN_CFG_RESET    2'h3
`define DOZE_SHORT_TOP   4'h5
`define DOZE_SHORT_STEP  4'h5
`define BAND_FAST_INDEX  3'h7
`define BAND_SLOW_INDEX  3'h0

// power mode fields
`define PM_SUSPEND_BIT   7
`define PM_REDUCED_BIT   6
`define PM_TIMER_BIT     5
`define PM_DOZE_HI       4
`define PM_DOZE_LO       1
// data setup fields
`define DS_RAW_BIT       7
`define DS_GUARD_BIT     6
// slope enable fields
`define SE_X_BIT         0
`define SE_Y_BIT         1
`define SE_Z_BIT         2
// data/fifo enable fields
`define DE_NEW_BIT       4
`define DE_FULL_BIT      5
`define DE_LEVEL_BIT     6
// motion map fields
`define MM_SIG_A_BIT     0
`define MM_SLOPE_A_BIT   2
`define MM_SLOPE_B_BIT   5
`define MM_SIG_B_BIT     7
// data map fields
`define DM_NEW_A_BIT     0
`define DM_LEVEL_A_BIT   1
`define DM_FULL_A_BIT    2
`define DM_FULL_B_BIT    5
`define DM_LEVEL_B_BIT   6
`define DM_NEW_B_BIT     7
// pin configuration fields
`define PC_A_LEVEL_BIT   0
`define PC_B_LEVEL_BIT   2

`endif

// ### axis_shadow.v
// one axis output pair with a coherent high-byte shadow
module axis_shadow (
   input  wire        clk_sys,   // system clock
   input  wire        clr,       // synchronous clear
   input  wire [11:0] sample,    // current selected sample
   input  wire        guard_on,  // protection active
   input  wire        low_read,  // low byte read this cycle
   output wire [7:0]  low_byte,  // low nibble in upper bits
   output wire [7:0]  high_byte  // upper eight bits
);
   reg [7:0] held;

   always @(posedge clk_sys) begin
      if (clr) begin
         held <= 8'h00;
      end else if (low_read) begin
         held <= sample[11:4];
      end
   end

   assign low_byte  = {sample[3:0], 4'h0};
   // held copy keeps the pair from one sample across a new-data update
   assign high_byte = guard_on ? held : sample[11:4];
endmodule // axis_shadow

// ### reg_bank_monitor.sv
// assertion checker for the configuration and interrupt register bank
module reg_bank_monitor (
   input logic       clk_sys,              // clock
   input logic       rst,                  // reset
   input logic [7:0] reg_addr,             // offset
   input logic [7:0] reg_wdata,            // write data
   input logic       reg_wr,               // write strobe
   input logic       reg_rd,               // read strobe
   input logic [7:0] reg_rdata,            // read data
   input logic       slope_evt_x,          // event
   input logic       slope_evt_y,          // event
   input logic       slope_evt_z,          // event
   input logic       sigmotion_evt,        // event
   input logic       new_data_evt,         // event
   input logic       queue_full_evt,       // event
   input logic       queue_level_evt,      // event
   input logic [4:0] filter_band_code,     // band code
   input logic [2:0] band_rate_index,      // band index
   input logic       suspend_on,           // suspend
   input logic       reduced_power_enable, // reduced power
   input logic       equidistant_sleep,    // sleep timing
   input logic [3:0] doze_length_code,     // doze code
   input logic [3:0] doze_length_index,    // doze index
   input logic       unfiltered_select,    // raw select
   input logic       shadow_guard_off,     // guard off
   input logic       irq_pin_a,            // pin a
   input logic       irq_pin_b             // pin b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] hist;
   wire  [6:0] ev = {queue_level_evt, queue_full_evt, new_data_evt, sigmotion_evt,
                     slope_evt_z, slope_evt_y, slope_evt_x};
   // a quiet history means the pins have no cause to move
   always @(posedge clk_sys) begin
      hist <= {hist[3:0], reg_wr | rst | (|ev)};
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_suspend_write: assert property (reg_wr && reg_addr == 8'h11 |=>
      suspend_on == $past(reg_wdata[7])) else $error("suspend bit not taken");
   a_reduced_write: assert property (reg_wr && reg_addr == 8'h11 |=>
      reduced_power_enable == $past(reg_wdata[6])) else $error("reduced power bit not taken");
   a_timer_write: assert property (reg_wr && reg_addr == 8'h11 |=>
      equidistant_sleep == $past(reg_wdata[5])) else $error("sleep timing bit not taken");
   a_doze_decode: assert property ($stable(doze_length_code) |-> doze_length_index ==
      (doze_length_code <= 4'h5 ? 4'h0 : doze_length_code - 4'h5)) else $error("doze index");
   a_band_decode: assert property ($stable(filter_band_code) |-> band_rate_index ==
      (filter_band_code[4] ? 3'h7 : (filter_band_code[3] ? filter_band_code[2:0] : 3'h0)))
      else $error("band index");
   a_raw_select: assert property (reg_wr && reg_addr == 8'h13 |=>
      unfiltered_select == $past(reg_wdata[7])) else $error("raw select bit not taken");
   a_guard_write: assert property (reg_wr && reg_addr == 8'h13 |=>
      shadow_guard_off == $past(reg_wdata[6])) else $error("guard bit not taken");
   a_key_restores: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata == 8'hb6 |->
      ##3 (filter_band_code == 5'h1f && !suspend_on && !shadow_guard_off))
      else $error("key write did not restore defaults");
   a_key_reads_zero: assert property (reg_rd && reg_addr == 8'h14 |=>
      reg_rdata == 8'h00) else $error("key register read not zero");
   a_rsvd_zero: assert property (reg_rd && reg_addr == 8'h10 |=>
      reg_rdata[7:5] == 3'h0) else $error("reserved band bits not zero");
   a_pin_quiet: assert property (hist == 5'h00 |->
      $stable(irq_pin_a) && $stable(irq_pin_b)) else $error("pin moved without cause");
   c_key: cover property (reg_wr && reg_addr == 8'h14 && reg_wdata == 8'hb6);
   c_pin_a: cover property ($rose(irq_pin_a));
   c_pin_b: cover property ($rose(irq_pin_b));
endmodule // reg_bank_monitor

bind accel_config_irq_regs reg_bank_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .slope_evt_x(slope_evt_x), .slope_evt_y(slope_evt_y),
   .slope_evt_z(slope_evt_z), .sigmotion_evt(sigmotion_evt), .new_data_evt(new_data_evt),
   .queue_full_evt(queue_full_evt), .queue_level_evt(queue_level_evt),
   .filter_band_code(filter_band_code), .band_rate_index(band_rate_index),
   .suspend_on(suspend_on), .reduced_power_enable(reduced_power_enable),
   .equidistant_sleep(equidistant_sleep), .doze_length_code(doze_length_code),
   .doze_length_index(doze_length_index), .unfiltered_select(unfiltered_select),
   .shadow_guard_off(shadow_guard_off), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));

// ### reg_host_model.sv
// host side of the register port: single-cycle write and read strobes
module reg_host_model (
   input  logic       clk_sys,   // clock
   input  logic [7:0] reg_rdata, // read data
   output logic [7:0] reg_addr,  // offset
   output logic [7:0] reg_wdata, // write data
   output logic       reg_wr,    // write strobe
   output logic       reg_rd     // read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d; // stale data must not look valid
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
endmodule // reg_host_model

// ### accel_config_irq_regs_tb.sv
// self-checking bench for the configuration and interrupt register bank
module accel_config_irq_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst, reg_wr, reg_rd, irq_pin_a, irq_pin_b;
   logic        suspend_on, reduced_power_enable, equidistant_sleep;
   logic        unfiltered_select, shadow_guard_off;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic [6:0]  ev;
   logic [4:0]  filter_band_code;
   logic [2:0]  band_rate_index;
   logic [3:0]  doze_length_code, doze_length_index;
   logic [11:0] filt_x, filt_y, filt_z, raw_x, raw_y, raw_z;
   int          n_mismatch = 0;
   int          checked = 0;
   reg_host_model h (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   accel_config_irq_regs DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .filt_x(filt_x), .filt_y(filt_y), .filt_z(filt_z), .raw_x(raw_x), .raw_y(raw_y),
      .raw_z(raw_z), .slope_evt_x(ev[0]), .slope_evt_y(ev[1]), .slope_evt_z(ev[2]),
      .sigmotion_evt(ev[3]), .new_data_evt(ev[4]), .queue_full_evt(ev[5]),
      .queue_level_evt(ev[6]), .filter_band_code(filter_band_code),
      .band_rate_index(band_rate_index), .suspend_on(suspend_on),
      .reduced_power_enable(reduced_power_enable), .equidistant_sleep(equidistant_sleep),
      .doze_length_code(doze_length_code), .doze_length_index(doze_length_index),
      .unfiltered_select(unfiltered_select), .shadow_guard_off(shadow_guard_off),
      .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      h.rd(a, d);
      chk("read data", exp, d);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      rchk(8'h10, 8'h1f);
      rchk(8'h11, 8'h00);
      rchk(8'h13, 8'h00);
      rchk(8'h14, 8'h00);
      rchk(8'h16, 8'h00);
      rchk(8'h17, 8'h00);
      rchk(8'h19, 8'h00);
      rchk(8'h3f, 8'h00);
      rchk(8'h1a, 8'h00);
      rchk(8'h20, 8'h05);
      chk("band index", 3'h7, band_rate_index);
      chk("doze index", 4'h0, doze_length_index);
      chk("irq pins", 2'b00, {irq_pin_a, irq_pin_b});
   endtask
   task automatic t_band();
      h.wr(8'h11, 8'h80);
      for (int i = 0; i < 32; i++) begin
         h.wr(8'h10, {3'b111, i[4:0]});
         settle(1);
         chk("band index", i[4] ? 3'h7 : (i[3] ? i[2:0] : 3'h0), band_rate_index);
         rchk(8'h10, {3'b000, i[4:0]});
         chk("band code", i[4:0], filter_band_code);
      end
   endtask
   task automatic t_power();
      h.wr(8'h11, 8'hff);
      settle(0);
      chk("power bits", 3'b111, {suspend_on, reduced_power_enable, equidistant_sleep});
      rchk(8'h11, 8'hfe);
      for (int i = 0; i < 16; i++) begin
         h.wr(8'h11, {3'b100, i[3:0], 1'b0});
         settle(1);
         chk("doze code", i[3:0], doze_length_code);
         chk("doze index", i < 6 ? 12'h0 : 12'(i - 5), doze_length_index);
      end
      h.wr(8'h11, 8'h00);
      settle(0);
      chk("power bits", 3'b000, {suspend_on, reduced_power_enable, equidistant_sleep});
   endtask
   task automatic t_data_path();
      h.wr(8'h13, 8'hff);
      settle(0);
      chk("setup bits", 2'b11, {unfiltered_select, shadow_guard_off});
      rchk(8'h13, 8'hc0);
      h.wr(8'h13, 8'h00);
      rchk(8'h02, 8'h30);
      @(posedge clk_sys);
      filt_x <= 12'h5a5;
      rchk(8'h03, 8'h12);
      h.wr(8'h13, 8'h80);
      rchk(8'h04, 8'ha0);
      h.wr(8'h13, 8'h40);
      rchk(8'h03, 8'h5a);
   endtask
   // one event pulse after one configuration write
   task automatic irq_case(input logic [7:0] a, input logic [7:0] v, input int e,
                           input logic [1:0] exp);
      h.wr(a, v);
      @(posedge clk_sys);
      ev <= 7'h01 << e;
      settle(1);
      chk("irq pins", exp, {irq_pin_a, irq_pin_b});
      @(posedge clk_sys);
      ev <= 7'h00;
   endtask
   task automatic t_irq();
      h.wr(8'h19, 8'h24);
      for (int i = 0; i < 3; i++) begin
         irq_case(8'h16, 8'h01 << i, i, 2'b11);
         irq_case(8'h16, 8'h00, i, 2'b00);
      end
      irq_case(8'h19, 8'h01, 3, 2'b10);
      irq_case(8'h19, 8'h80, 3, 2'b01);
      irq_case(8'h19, 8'h00, 3, 2'b00);
      irq_case(8'h1a, 8'h01, 4, 2'b00);
      irq_case(8'h17, 8'h10, 4, 2'b10);
      irq_case(8'h1a, 8'h04, 5, 2'b00);
      irq_case(8'h17, 8'h70, 5, 2'b10);
      irq_case(8'h1a, 8'h02, 6, 2'b10);
      irq_case(8'h1a, 8'h02, 5, 2'b00);
      irq_case(8'h1a, 8'h20, 5, 2'b01);
      irq_case(8'h1a, 8'h40, 6, 2'b01);
      irq_case(8'h1a, 8'h80, 4, 2'b01);
      h.wr(8'h20, 8'h00);
      settle(1);
      chk("irq idle", 2'b11, {irq_pin_a, irq_pin_b});
      irq_case(8'h19, 8'h01, 3, 2'b01);
   endtask
   task automatic t_soft_reset();
      h.wr(8'h16, 8'h07);
      h.wr(8'h10, 8'h05);
      h.wr(8'h14, 8'h5a);
      rchk(8'h16, 8'h07);
      h.wr(8'h14, 8'hb6);
      repeat (2) @(posedge clk_sys);
      rchk(8'h10, 8'h1f);
      rchk(8'h16, 8'h00);
      chk("irq pins", 2'b00, {irq_pin_a, irq_pin_b});
   endtask
   task automatic report_and_stop();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      ev = 7'h00;
      filt_x = 12'h123;
      filt_y = 12'h456;
      filt_z = 12'h789;
      raw_x = 12'hfed;
      raw_y = 12'hcba;
      raw_z = 12'h987;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset_values();
      t_band();
      t_power();
      t_data_path();
      t_irq();
      t_soft_reset();
      report_and_stop();
   end
   // the whole run is under two thousand cycles; twenty thousand means a hang
   initial begin
      #800000;
      n_mismatch++;
      report_and_stop();
   end
endmodule // accel_config_irq_regs_tb
